// file: inc/rcafr_consts.svh
`ifndef RCAFR_CONSTS_SVH
`define RCAFR_CONSTS_SVH

// Cause flag positions
`define RCAFR_POR_BIT     7
`define RCAFR_PIN_BIT     6
`define RCAFR_WDOG_BIT    5
`define RCAFR_BADOP_BIT   4
`define RCAFR_BADADDR_BIT 3
`define RCAFR_LOWV_BIT    1

// Values after power-on
`define RCAFR_POR_FLAGS   8'h82
`define RCAFR_ZERO_BYTE   8'h00

// Watchdog service sequence
`define RCAFR_SVC_FIRST   8'h55
`define RCAFR_SVC_SECOND  8'haa

// Forced reset bit in the debug register
`define RCAFR_FORCE_BIT   0

// Least hold of a system reset, in cycles
`define RCAFR_HOLD_CYCLES 16

`endif

// file: inc/rcafr_pkg.sv
package rcafr_pkg;

    typedef logic [7:0] rcafr_byte_t;

    typedef enum logic [1:0] {
        ST_RUN  = 2'b01,
        ST_HOLD = 2'b10
    } rcafr_state_e;

endpackage : rcafr_pkg

// file: src/rcafr_reset_cause.sv
`timescale 1ns/100ps
`include "rcafr_consts.svh"

module rcafr_reset_cause
    import rcafr_pkg::*;
#(
    parameter int HOLD_CYCLES = `RCAFR_HOLD_CYCLES
) (
    input  wire logic        core_clk,
    input  wire logic        rst_n,
    input  wire logic        cpuStatusSel,
    input  wire logic        cpuDebugSel,
    input  wire logic        cpuWrEn,
    input  wire logic        cpuRdEn,
    input  wire logic [7:0]  cpuWrData,
    output logic      [7:0]  cpuRdData,
    input  wire logic        bdmDebugWrEn,
    input  wire logic [7:0]  bdmWrData,
    input  wire logic        resetPinN,
    input  wire logic        lowVoltageSense,
    input  wire logic        low_voltage_reset_enable,
    input  wire logic        watchdog_enable,
    input  wire logic        watchdog_window_select,
    input  wire logic        watchdogLateQuarter,
    input  wire logic        watchdogTimeout,
    input  wire logic        illegalOpcode,
    input  wire logic        stopInstruction,
    input  wire logic        stop_allow,
    input  wire logic        debug_halt_instruction,
    input  wire logic        background_mode_allow,
    input  wire logic        illegalAddress,
    output logic             watchdogRestart,
    output logic             sysReset
);

    rcafr_state_e state_q;
    rcafr_byte_t  causeFlags_q;
    logic         svcArmed_q;
    logic [15:0]  holdCnt_q;
    logic [2:0]   pinSync_q;
    logic [2:0]   lowvSync_q;

    logic         pinLow_q;
    logic         lowvLow_q;

    logic         running;
    logic         statusWrite;
    logic         wdogWriteFault;
    logic         forceReq;

    logic         pinSrc;
    logic         wdogSrc;
    logic         badOpSrc;
    logic         badAddrSrc;
    logic         lowvSrc;
    logic         anySrc;
    logic         holdDone;

    rcafr_byte_t  entryFlags_d;
    rcafr_byte_t  cpuRdData_d;

    // True for either byte of the service sequence
    function automatic logic isServiceByte(input rcafr_byte_t value);
        logic hit;
        hit = 1'b0;
        if (value == `RCAFR_SVC_FIRST) begin
            hit = 1'b1;
        end
        if (value == `RCAFR_SVC_SECOND) begin
            hit = 1'b1;
        end
        return hit;
    endfunction : isServiceByte

    // Cause byte to store at reset entry
    function automatic rcafr_byte_t entryFlags(
        input rcafr_byte_t prevFlags,
        input logic        lowvEntry,
        input logic        pinEntry,
        input logic        wdogEntry,
        input logic        badOpEntry,
        input logic        badAddrEntry
    );
        rcafr_byte_t flags;
        flags = `RCAFR_ZERO_BYTE;
        if (lowvEntry) begin
            flags[`RCAFR_POR_BIT]  = prevFlags[`RCAFR_POR_BIT];
            flags[`RCAFR_LOWV_BIT] = 1'b1;
        end else begin
            flags[`RCAFR_PIN_BIT]     = pinEntry;
            flags[`RCAFR_WDOG_BIT]    = wdogEntry;
            flags[`RCAFR_BADOP_BIT]   = badOpEntry;
            flags[`RCAFR_BADADDR_BIT] = badAddrEntry;
        end
        return flags;
    endfunction : entryFlags

    // Reset pin synchroniser
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            pinSync_q <= 3'h7;
        end else begin
            pinSync_q <= {pinSync_q[1:0], resetPinN};
        end
    end

    // Low-voltage sense synchroniser
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            lowvSync_q <= 3'h0;
        end else begin
            lowvSync_q <= {lowvSync_q[1:0], lowVoltageSense};
        end
    end

    // Pin level changes once stages two and three agree
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            pinLow_q <= 1'b0;
        end else if (pinSync_q[1] == pinSync_q[2]) begin
            pinLow_q <= ~pinSync_q[2];
        end
    end

    // Same filter for the low-voltage sense
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            lowvLow_q <= 1'b0;
        end else if (lowvSync_q[1] == lowvSync_q[2]) begin
            lowvLow_q <= lowvSync_q[2];
        end
    end

    assign running     = (state_q == ST_RUN);
    assign statusWrite = running && cpuStatusSel && cpuWrEn;

    // Bad value, or any write in the closed window
    always_comb begin
        wdogWriteFault = 1'b0;
        if (statusWrite && watchdog_enable) begin
            if (!isServiceByte(cpuWrData)) begin
                wdogWriteFault = 1'b1;
            end
            if (watchdog_window_select && !watchdogLateQuarter) begin
                wdogWriteFault = 1'b1;
            end
        end
    end

    // Only the background port reaches the force bit
    assign forceReq = running && bdmDebugWrEn && bdmWrData[`RCAFR_FORCE_BIT];

    assign pinSrc  = pinLow_q;
    assign wdogSrc = watchdog_enable && (watchdogTimeout || wdogWriteFault);
    assign badOpSrc = illegalOpcode
                      || (stopInstruction && !stop_allow)
                      || (debug_halt_instruction && !background_mode_allow);
    assign badAddrSrc = illegalAddress;
    assign lowvSrc    = low_voltage_reset_enable && lowvLow_q;
    assign anySrc     = pinSrc || wdogSrc || badOpSrc || badAddrSrc || lowvSrc || forceReq;

    // Reset is held while the pin is still low, or the supply is still low with low-voltage reset enabled
    assign holdDone = (holdCnt_q == 16'h0000) && !pinLow_q && !lowvSrc;

    // Reset sequencing
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            state_q   <= ST_RUN;
            holdCnt_q <= 16'h0000;
        end else begin
            case (state_q)
                ST_RUN: begin
                    if (anySrc) begin
                        state_q   <= ST_HOLD;
                        holdCnt_q <= 16'(HOLD_CYCLES - 1);
                    end
                end
                ST_HOLD: begin
                    if (holdCnt_q != 16'h0000) begin
                        holdCnt_q <= holdCnt_q - 16'h0001;
                    end
                    if (holdDone) begin
                        state_q <= ST_RUN;
                    end
                end
                default: begin
                    state_q   <= ST_HOLD;
                    holdCnt_q <= 16'(HOLD_CYCLES - 1);
                end
            endcase
        end
    end

    // Cause flags loaded at reset entry
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            causeFlags_q <= `RCAFR_POR_FLAGS;
        end else if (running && anySrc) begin
            causeFlags_q <= entryFlags_d;
        end
    end

    // Low-voltage entry wins over the other sources
    assign entryFlags_d = entryFlags(causeFlags_q, lowvSrc, pinSrc, wdogSrc,
                                     badOpSrc, badAddrSrc);

    // Service sequence tracking
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            svcArmed_q      <= 1'b0;
            watchdogRestart <= 1'b0;
        end else begin
            watchdogRestart <= 1'b0;
            if (!running || anySrc) begin
                svcArmed_q <= 1'b0;
            end else if (statusWrite) begin
                if (cpuWrData == `RCAFR_SVC_FIRST) begin
                    svcArmed_q <= 1'b1;
                end else begin
                    svcArmed_q <= 1'b0;
                    if ((cpuWrData == `RCAFR_SVC_SECOND) && svcArmed_q) begin
                        watchdogRestart <= 1'b1;
                    end
                end
            end
        end
    end

    // Read select; debug register always returns zero
    always_comb begin
        cpuRdData_d = `RCAFR_ZERO_BYTE;
        if (cpuRdEn && cpuStatusSel) begin
            cpuRdData_d = causeFlags_q;
        end else if (cpuRdEn && cpuDebugSel) begin
            cpuRdData_d = `RCAFR_ZERO_BYTE;
        end
    end

    // Registered read data, zero outside a read
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            cpuRdData <= `RCAFR_ZERO_BYTE;
        end else begin
            cpuRdData <= cpuRdData_d;
        end
    end

    // System reset level follows the hold state

    assign sysReset = (state_q == ST_HOLD);

endmodule : rcafr_reset_cause

// file: test/rcafr_debug_host.sv
`timescale 1ns/100ps
module rcafr_debug_host (
    input  wire logic       core_clk,
    input  wire logic       sendReq,
    input  wire logic [7:0] sendVal,
    output logic            bdmDebugWrEn,
    output logic      [7:0] bdmWrData
);
    initial begin
        bdmDebugWrEn = 1'b0;
        bdmWrData = 8'h00;
    end
    // One-cycle byte write, then the data lines toggle while idle
    always @(negedge core_clk) begin
        bdmDebugWrEn <= sendReq;
        bdmWrData <= sendReq ? sendVal : ~bdmWrData;
    end
endmodule : rcafr_debug_host

// file: test/rcafr_checker.sv
`timescale 1ns/100ps
module rcafr_checker (
    input wire logic       core_clk,
    input wire logic       rst_n,
    input wire logic       cpuStatusSel,
    input wire logic       cpuDebugSel,
    input wire logic       cpuWrEn,
    input wire logic       cpuRdEn,
    input wire logic [7:0] cpuWrData,
    input wire logic [7:0] cpuRdData,
    input wire logic       bdmDebugWrEn,
    input wire logic [7:0] bdmWrData,
    input wire logic       watchdog_enable,
    input wire logic       watchdogRestart,
    input wire logic       sysReset
);
    default clocking @(posedge core_clk); endclocking
    default disable iff (!rst_n);
    wire logic statWr = cpuWrEn && cpuStatusSel && !sysReset;
    dbg_zero_a: assert property (cpuRdEn && cpuDebugSel && !cpuStatusSel
        |=> cpuRdData == 8'h00) else $error("debug read not zero");
    idle_zero_a: assert property (!cpuRdEn |=> cpuRdData == 8'h00)
        else $error("idle read data");
    unused_bits_a: assert property (cpuRdEn && cpuStatusSel
        |=> !cpuRdData[2] && !cpuRdData[0]) else $error("unused bits set");
    bad_write_a: assert property (statWr && watchdog_enable && cpuWrData != 8'h55
        && cpuWrData != 8'haa |=> sysReset) else $error("no reset on bad write");
    force_reset_a: assert property (bdmDebugWrEn && bdmWrData[0] && !sysReset
        |=> sysReset) else $error("no forced reset");
    reset_hold_a: assert property ($rose(sysReset) |-> sysReset[*2])
        else $error("reset too short");
    restart_src_a: assert property (watchdogRestart
        |-> $past(statWr && cpuWrData == 8'haa)) else $error("stray restart");
    restart_pulse_a: assert property (watchdogRestart |=> !watchdogRestart)
        else $error("restart too long");
    cover property (watchdogRestart);
    cover property ($rose(sysReset));
    cover property (cpuRdEn && cpuStatusSel);
endmodule : rcafr_checker
bind rcafr_reset_cause rcafr_checker chk_u (.*);

// file: test/tb_top.sv
`timescale 1ns/100ps
module tb_top;
    logic core_clk = 0, rst_n = 0, cpuStatusSel = 0, cpuDebugSel = 0, cpuWrEn = 0;
    logic cpuRdEn = 0, resetPinN = 1, lowVoltageSense = 0, low_voltage_reset_enable = 1;
    logic watchdog_enable = 1, watchdog_window_select = 1, watchdogLateQuarter = 1;
    logic watchdogTimeout = 0, illegalOpcode = 0, stopInstruction = 0, stop_allow = 0;
    logic debug_halt_instruction = 0, background_mode_allow = 0, illegalAddress = 0;
    logic sendReq = 0, bdmDebugWrEn, watchdogRestart, sysReset;
    logic [7:0] cpuWrData = 8'h00, sendVal = 8'h00, cpuRdData, bdmWrData, got;
    logic [7:0] expTab [10] = '{8'h40, 8'h20, 8'h10, 8'h10, 8'h10, 8'h08, 8'h02, 8'h20, 8'h00,
        8'h20};
    int err_count = 0, checks_done = 0;
    initial forever #5 core_clk = ~core_clk;
    rcafr_reset_cause #(.HOLD_CYCLES(2)) dut_u (.*);
    rcafr_debug_host host_u (.core_clk(core_clk), .sendReq(sendReq), .sendVal(sendVal),
        .bdmDebugWrEn(bdmDebugWrEn), .bdmWrData(bdmWrData));
    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        checks_done++;
        if (seen !== exp) begin
            err_count++;
            $display("ERROR %0t seen %h expected %h", $time, seen, exp);
        end
    endtask : check
    task automatic conclude;
        $display("Mismatches %0d, checks %0d", err_count, checks_done);
        if (err_count == 0 && checks_done > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask : conclude
    task automatic waitRst(input logic lvl);
        int n = 0;
        while (sysReset !== lvl && n < 40) begin
            @(negedge core_clk);
            n++;
        end
        if (n == 40) begin
            err_count++;
            conclude();
        end
    endtask : waitRst
    task automatic rd(input logic dbg, output logic [7:0] v);
        {cpuStatusSel, cpuDebugSel, cpuRdEn} <= {~dbg, dbg, 1'b1};
        @(negedge core_clk);
        v = cpuRdData;
        cpuRdEn <= 1'b0;
    endtask : rd
    task automatic wr(input logic [7:0] d);
        {cpuStatusSel, cpuDebugSel, cpuWrEn, cpuWrData} <= {3'b101, d};
        @(negedge core_clk);
        cpuWrEn <= 1'b0;
    endtask : wr
    task automatic tPowerOn;
        rd(1'b0, got);
        check(got, 8'h82);
        rd(1'b1, got);
        check(got, 8'h00);
    endtask : tPowerOn
    task automatic tService;
        wr(8'h55);
        @(negedge core_clk);
        wr(8'haa);
        check({7'h00, watchdogRestart}, 8'h01);
        @(negedge core_clk);
        check({7'h00, watchdogRestart}, 8'h00);
        rd(1'b0, got);
        check(got, 8'h82);
    endtask : tService
    task automatic tIgnored;
        {cpuStatusSel, cpuDebugSel, cpuWrEn, cpuWrData} <= {3'b011, 8'h01};
        {sendReq, sendVal} <= {1'b1, 8'h00};
        @(negedge core_clk);
        {cpuWrEn, sendReq} <= 2'b00;
        repeat (5) @(negedge core_clk);
        check({7'h00, sysReset}, 8'h00);
    endtask : tIgnored
    task automatic tCause(input int k);
        case (k)
            0: resetPinN <= 1'b0;
            1: watchdogTimeout <= 1'b1;
            2: illegalOpcode <= 1'b1;
            3: stopInstruction <= 1'b1;
            4: debug_halt_instruction <= 1'b1;
            5: illegalAddress <= 1'b1;
            6: lowVoltageSense <= 1'b1;
            7: begin
                watchdogLateQuarter <= 1'b0;
                wr(8'h55);
            end
            8: {sendReq, sendVal} <= {1'b1, 8'h01};
            default: wr(8'h12);
        endcase
        @(negedge core_clk);
        {watchdogTimeout, illegalOpcode, stopInstruction, sendReq, cpuWrEn} <= 5'h00;
        {debug_halt_instruction, illegalAddress} <= 2'b00;
        waitRst(1'b1);
        {resetPinN, lowVoltageSense, watchdogLateQuarter} <= 3'b101;
        waitRst(1'b0);
        rd(1'b0, got);
        check(got, expTab[k]);
    endtask : tCause
    initial begin
        repeat (16) @(negedge core_clk);
        rst_n <= 1'b1;
        @(negedge core_clk);
        tPowerOn();
        tService();
        tIgnored();
        for (int k = 0; k < 10; k++) tCause(k);
        rd(1'b1, got);
        check(got, 8'h00);
        conclude();
    end
endmodule : tb_top
